/* spe_pkg.sv */
`default_nettype none

package spe_pkg;

    localparam int SPE_PINS = 7;
    localparam int SPE_ADDR_W = 12;
    localparam int SPE_DATA_W = 32;

    // Register byte offsets within the port window
    localparam logic [11:0] SPE_OFS_PIN_DATA = 12'h000;
    localparam logic [11:0] SPE_OFS_OUTPUT_ENABLE = 12'h004;
    localparam logic [11:0] SPE_OFS_FUNCTION_ONE = 12'h008;
    localparam logic [11:0] SPE_OFS_FUNCTION_TWO = 12'h00C;
    localparam logic [11:0] SPE_OFS_OPEN_DRAIN = 12'h028;
    localparam logic [11:0] SPE_OFS_PULLUP = 12'h02C;
    localparam logic [11:0] SPE_OFS_INPUT_ENABLE = 12'h038;

    localparam logic [6:0] SPE_RESET_BITS = 7'h00;
    localparam logic [6:0] SPE_FUNCTION_ONE_MASK = 7'h7F;
    localparam logic [6:0] SPE_FUNCTION_TWO_MASK = 7'h44;
    localparam logic [31:0] SPE_READ_ZERO = 32'h0000_0000;

    // Pin positions of the alternate functions
    localparam int SPE_BIT_S0_TX = 0;
    localparam int SPE_BIT_S0_RX = 1;
    localparam int SPE_BIT_S0_CLK = 2;
    localparam int SPE_BIT_RESERVED = 3;
    localparam int SPE_BIT_S1_TX = 4;
    localparam int SPE_BIT_S1_RX = 5;
    localparam int SPE_BIT_S1_CLK = 6;
    localparam int SPE_BIT_S0_CTS = 2;
    localparam int SPE_BIT_S1_CTS = 6;

    // Level a peripheral input sees while its pin is not routed to it
    localparam logic SPE_IDLE_LEVEL = 1'b1;

endpackage : spe_pkg

`default_nettype wire

/* spe_port.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01 - Data register: seven bits, reset zero
// RULE_02 - Output control bit enables pin driver
// RULE_03 - Function one routes pins to serial channels
// RULE_04 - Function one bit three is reserved
// RULE_05 - Function two routes clear-to-send inputs
// RULE_06 - Open-drain bit selects drain-only output
// RULE_07 - Pull-up control bit enables pin pull-up
// RULE_08 - Input control bit opens input path
// RULE_09 - Never set both function bits together
// RULE_10 - Selected peripheral drives and receives pin
module spe_port
    import spe_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SPE_ADDR_W-1:0] paddr,
    input wire logic [SPE_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [SPE_DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic [SPE_PINS-1:0] pin_in,
    output logic [SPE_PINS-1:0] pin_out,
    output logic [SPE_PINS-1:0] pin_oe,
    output logic [SPE_PINS-1:0] pin_pullup,
    input wire logic serial0_transmit,
    input wire logic serial0_clock_drive,
    output logic serial0_receive,
    output logic serial0_clock,
    output logic serial0_clear_to_send,
    input wire logic serial1_transmit,
    input wire logic serial1_clock_drive,
    output logic serial1_receive,
    output logic serial1_clock,
    output logic serial1_clear_to_send
);

    logic [SPE_PINS-1:0] pin_data;
    logic [SPE_PINS-1:0] output_enable;
    logic [SPE_PINS-1:0] function_select_one;
    logic [SPE_PINS-1:0] function_select_two;
    logic [SPE_PINS-1:0] open_drain_select;
    logic [SPE_PINS-1:0] pullup_enable;
    logic [SPE_PINS-1:0] input_enable;
    logic [SPE_PINS-1:0] pin_meta;
    logic [SPE_PINS-1:0] pin_sync;
    logic [SPE_PINS-1:0] pin_seen;
    logic [SPE_PINS-1:0] routed_one;
    logic [SPE_PINS-1:0] routed_two;
    logic [SPE_PINS-1:0] next_pin_out;
    logic [SPE_PINS-1:0] next_pin_oe;
    logic [SPE_PINS-1:0] data_view;
    logic [SPE_DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic setup_phase;
    logic write_take;
    logic [SPE_PINS-1:0] wdata;

    function automatic logic spe_hit(
        input logic [SPE_ADDR_W-1:0] addr,
        input logic [SPE_ADDR_W-1:0] ofs
    );
        spe_hit = (addr == ofs);
    endfunction : spe_hit

    function automatic logic [SPE_DATA_W-1:0] spe_word(
        input logic [SPE_PINS-1:0] bits
    );
        spe_word = {{(SPE_DATA_W-SPE_PINS){1'b0}}, bits};
    endfunction : spe_word

    function automatic logic spe_route_in(
        input logic sel,
        input logic level
    );
        spe_route_in = sel ? level : SPE_IDLE_LEVEL;
    endfunction : spe_route_in

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign setup_phase = psel && !penable;
    // Only byte lane 0 carries register bits
    assign write_take = psel && penable && pwrite && pstrb[0];
    assign wdata = pwdata[SPE_PINS-1:0];

    always_ff @(posedge clock) begin
        if (srst) begin
            pin_data <= SPE_RESET_BITS; // RULE_01
        end else if (write_take && spe_hit(paddr, SPE_OFS_PIN_DATA)) begin
            pin_data <= wdata; // RULE_01
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            output_enable <= SPE_RESET_BITS; // RULE_02
        end else if (write_take && spe_hit(paddr, SPE_OFS_OUTPUT_ENABLE)) begin
            output_enable <= wdata; // RULE_02
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            function_select_one <= SPE_RESET_BITS; // RULE_03
        end else if (write_take && spe_hit(paddr, SPE_OFS_FUNCTION_ONE)) begin
            function_select_one <= wdata & SPE_FUNCTION_ONE_MASK; // RULE_03
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            function_select_two <= SPE_RESET_BITS; // RULE_05
        end else if (write_take && spe_hit(paddr, SPE_OFS_FUNCTION_TWO)) begin
            function_select_two <= wdata & SPE_FUNCTION_TWO_MASK; // RULE_05
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            open_drain_select <= SPE_RESET_BITS; // RULE_06
        end else if (write_take && spe_hit(paddr, SPE_OFS_OPEN_DRAIN)) begin
            open_drain_select <= wdata; // RULE_06
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pullup_enable <= SPE_RESET_BITS; // RULE_07
        end else if (write_take && spe_hit(paddr, SPE_OFS_PULLUP)) begin
            pullup_enable <= wdata; // RULE_07
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            input_enable <= SPE_RESET_BITS; // RULE_08
        end else if (write_take && spe_hit(paddr, SPE_OFS_INPUT_ENABLE)) begin
            input_enable <= wdata; // RULE_08
        end
    end

    // Pins are asynchronous to the clock
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_meta <= SPE_RESET_BITS;
        end else begin
            pin_meta <= pin_in;
        end
    end

    // Only this second stage feeds any logic
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_sync <= SPE_RESET_BITS;
        end else begin
            pin_sync <= pin_meta;
        end
    end

    // A blocked input reads low so a floating pin draws no current
    assign pin_seen = pin_sync & input_enable; // RULE_08

    // Function one wins if software sets both; the reserved
    // selection is treated as a plain port pin
    always_comb begin
        routed_one = function_select_one; // RULE_03
        routed_one[SPE_BIT_RESERVED] = 1'b0; // RULE_04
    end

    always_comb begin
        routed_two = function_select_two & ~function_select_one; // RULE_09
    end

    // Pin output value and driver enable
    always_comb begin
        next_pin_out = pin_data;
        if (routed_one[SPE_BIT_S0_TX]) begin
            next_pin_out[SPE_BIT_S0_TX] = serial0_transmit; // RULE_10
        end
        if (routed_one[SPE_BIT_S0_CLK]) begin
            next_pin_out[SPE_BIT_S0_CLK] = serial0_clock_drive; // RULE_10
        end
        if (routed_one[SPE_BIT_S1_TX]) begin
            next_pin_out[SPE_BIT_S1_TX] = serial1_transmit; // RULE_10
        end
        if (routed_one[SPE_BIT_S1_CLK]) begin
            next_pin_out[SPE_BIT_S1_CLK] = serial1_clock_drive; // RULE_10
        end
    end

    // Open-drain only pulls low; a high level is left to the pull-up
    always_comb begin
        next_pin_oe = output_enable & ~(open_drain_select & next_pin_out); // RULE_02 RULE_06
    end

    // Outputs are registered to keep pin timing glitch free
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_out <= SPE_RESET_BITS;
        end else begin
            pin_out <= next_pin_out; // RULE_10
        end
    end

    // Driver enable moves in the same cycle as the level
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_oe <= SPE_RESET_BITS; // RULE_02
        end else begin
            pin_oe <= next_pin_oe; // RULE_02 RULE_06
        end
    end

    // Pull-up enable
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_pullup <= SPE_RESET_BITS; // RULE_07
        end else begin
            pin_pullup <= pullup_enable; // RULE_07
        end
    end

    // Peripheral inputs, idle high while not routed
    // Channel 0 receive
    always_ff @(posedge clock) begin
        if (srst) begin
            serial0_receive <= SPE_IDLE_LEVEL;
        end else begin
            serial0_receive <= spe_route_in(routed_one[SPE_BIT_S0_RX],
                pin_seen[SPE_BIT_S0_RX]); // RULE_10
        end
    end

    // Channel 0 serial clock
    always_ff @(posedge clock) begin
        if (srst) begin
            serial0_clock <= SPE_IDLE_LEVEL;
        end else begin
            serial0_clock <= spe_route_in(routed_one[SPE_BIT_S0_CLK],
                pin_seen[SPE_BIT_S0_CLK]); // RULE_10
        end
    end

    // Channel 0 clear-to-send
    always_ff @(posedge clock) begin
        if (srst) begin
            serial0_clear_to_send <= SPE_IDLE_LEVEL;
        end else begin
            serial0_clear_to_send <= spe_route_in(routed_two[SPE_BIT_S0_CTS],
                pin_seen[SPE_BIT_S0_CTS]); // RULE_05
        end
    end

    // Channel 1 receive
    always_ff @(posedge clock) begin
        if (srst) begin
            serial1_receive <= SPE_IDLE_LEVEL;
        end else begin
            serial1_receive <= spe_route_in(routed_one[SPE_BIT_S1_RX],
                pin_seen[SPE_BIT_S1_RX]); // RULE_10
        end
    end

    // Channel 1 serial clock
    always_ff @(posedge clock) begin
        if (srst) begin
            serial1_clock <= SPE_IDLE_LEVEL;
        end else begin
            serial1_clock <= spe_route_in(routed_one[SPE_BIT_S1_CLK],
                pin_seen[SPE_BIT_S1_CLK]); // RULE_10
        end
    end

    // Channel 1 clear-to-send
    always_ff @(posedge clock) begin
        if (srst) begin
            serial1_clear_to_send <= SPE_IDLE_LEVEL;
        end else begin
            serial1_clear_to_send <= spe_route_in(routed_two[SPE_BIT_S1_CTS],
                pin_seen[SPE_BIT_S1_CTS]); // RULE_05
        end
    end

    // Data reads show the pin where input is enabled, else the latch
    assign data_view = (pin_data & ~input_enable) | pin_seen; // RULE_01 RULE_08

    always_comb begin
        next_prdata = SPE_READ_ZERO;
        next_pslverr = 1'b0;
        unique case (paddr)
            SPE_OFS_PIN_DATA: begin
                next_prdata = spe_word(data_view); // RULE_01
            end
            SPE_OFS_OUTPUT_ENABLE: begin
                next_prdata = spe_word(output_enable); // RULE_02
            end
            SPE_OFS_FUNCTION_ONE: begin
                next_prdata = spe_word(function_select_one); // RULE_03
            end
            SPE_OFS_FUNCTION_TWO: begin
                next_prdata = spe_word(function_select_two); // RULE_05
            end
            SPE_OFS_OPEN_DRAIN: begin
                next_prdata = spe_word(open_drain_select); // RULE_06
            end
            SPE_OFS_PULLUP: begin
                next_prdata = spe_word(pullup_enable); // RULE_07
            end
            SPE_OFS_INPUT_ENABLE: begin
                next_prdata = spe_word(input_enable); // RULE_08
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= SPE_READ_ZERO;
        end else if (setup_phase) begin
            prdata <= pwrite ? SPE_READ_ZERO : next_prdata;
        end
    end

    // Error stands from setup until the next setup cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= next_pslverr;
        end
    end

endmodule : spe_port

`default_nettype wire

/* spe_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module spe_port_checker
    import spe_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SPE_ADDR_W-1:0] paddr,
    input wire logic [SPE_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [SPE_DATA_W-1:0] prdata,
    input wire logic [SPE_PINS-1:0] pin_out,
    input wire logic [SPE_PINS-1:0] pin_oe,
    input wire logic [SPE_PINS-1:0] pin_pullup,
    input wire logic serial1_receive,
    input wire logic serial0_clear_to_send,
    input wire logic serial1_clear_to_send
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic wr;
    // A write lands only with the low byte strobe
    assign wr = psel && penable && pwrite && pstrb[0];
    upper_zero_a: assert property (psel && penable |-> prdata[31:7] == 25'h0)
        else $error("upper read bits not zero");
    fn_two_gap_a: assert property (psel && penable && !pwrite
        && paddr == SPE_OFS_FUNCTION_TWO |-> prdata[5:3] == 3'h0 && prdata[1:0] == 2'h0)
        else $error("gap bits set");
    reset_clear_a: assert property (disable iff (1'b0) srst
        |=> pin_out == 7'h00 && pin_oe == 7'h00 && pin_pullup == 7'h00) else $error("reset");
    oe_clear_a: assert property (wr && paddr == SPE_OFS_OUTPUT_ENABLE
        && pwdata[6:0] == 7'h00 |-> ##2 pin_oe == 7'h00) else $error("driver left on");
    pullup_set_a: assert property (wr && paddr == SPE_OFS_PULLUP
        |-> ##2 pin_pullup == $past(pwdata[6:0], 2)) else $error("pull-up mismatch");
    drain_low_a: assert property (wr && paddr == SPE_OFS_OPEN_DRAIN
        && pwdata[6:0] == 7'h7F |-> ##2 (pin_oe & pin_out) == 7'h00) else $error("drove high");
    serial0_clear_to_send_idle_a: assert property (wr && paddr == SPE_OFS_FUNCTION_TWO
        && !pwdata[2] |-> ##2 serial0_clear_to_send) else $error("serial0_clear_to_send not idle");
    serial1_clear_to_send_idle_a: assert property (wr && paddr == SPE_OFS_FUNCTION_TWO
        && !pwdata[6] |-> ##2 serial1_clear_to_send) else $error("serial1_clear_to_send not idle");
    rx1_idle_a: assert property (wr && paddr == SPE_OFS_FUNCTION_ONE
        && !pwdata[5] |-> ##2 serial1_receive) else $error("rx1 not idle");
endmodule : spe_port_checker
bind spe_port spe_port_checker i_spe_port_checker (.clock, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pin_out, .pin_oe, .pin_pullup, .serial1_receive,
    .serial0_clear_to_send, .serial1_clear_to_send);
`default_nettype wire

/* spe_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spe_far_model
    import spe_pkg::*;
(
    input wire logic clock,
    input wire logic [SPE_PINS-1:0] pin_out,
    input wire logic [SPE_PINS-1:0] pin_oe,
    input wire logic [SPE_PINS-1:0] pin_pullup,
    input wire logic [SPE_PINS-1:0] ext_drv,
    input wire logic [SPE_PINS-1:0] ext_val,
    input wire logic [3:0] ser_val,
    output logic [SPE_PINS-1:0] pin_in,
    output logic serial0_transmit,
    output logic serial0_clock_drive,
    output logic serial1_transmit,
    output logic serial1_clock_drive
);
    logic [SPE_PINS-1:0] flt = 7'h55;
    // A floating pin wanders, so no test may lean on its level
    always @(posedge clock) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < SPE_PINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pin_pullup[i] | flt[i];
        end
    end
    assign {serial1_clock_drive, serial1_transmit, serial0_clock_drive, serial0_transmit} = ser_val;
endmodule : spe_far_model
`default_nettype wire

/* spe_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spe_port_tb
    import spe_pkg::*;
;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rerr;
    logic pready, pslverr, serial0_transmit, serial0_clock_drive, serial1_transmit;
    logic serial1_clock_drive, serial0_receive, serial0_clock, serial0_clear_to_send;
    logic serial1_receive, serial1_clock, serial1_clear_to_send;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hF, ser_val = 4'h0, sv;
    logic [6:0] ext_drv = 7'h00, ext_val = 7'h00, pin_in, pin_out, pin_oe, pin_pullup;
    int errors = 0, compares = 0;
    logic [11:0] ofs [7] = '{SPE_OFS_PIN_DATA, SPE_OFS_OUTPUT_ENABLE, SPE_OFS_FUNCTION_ONE,
        SPE_OFS_FUNCTION_TWO, SPE_OFS_OPEN_DRAIN, SPE_OFS_PULLUP, SPE_OFS_INPUT_ENABLE};
    // Function one skips bit 3 and shares no pin with function two
    logic [31:0] wv [7] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000033, 32'hFFFFFFFF,
        32'h00000080, 32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0] ev [7] = '{32'h0000006E, 32'h0000007F, 32'h00000033, 32'h00000044,
        32'h00000000, 32'h0000007F, 32'h0000007F};
    assign sv = {serial1_clear_to_send, serial0_clear_to_send, serial1_receive, serial0_receive};
    always #2 clock = ~clock;
    spe_port i_spe_port (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .serial0_transmit,
        .serial0_clock_drive, .serial0_receive, .serial0_clock, .serial0_clear_to_send,
        .serial1_transmit, .serial1_clock_drive, .serial1_receive, .serial1_clock,
        .serial1_clear_to_send);
    spe_far_model i_spe_far_model (.clock, .pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_val,
        .ser_val, .pin_in, .serial0_transmit, .serial0_clock_drive, .serial1_transmit,
        .serial1_clock_drive);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task end_sim;
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) begin apb(ofs[i], 0, 0); chk(rdat, 0); end
        for (int i = 0; i < 7; i++) apb(ofs[i], 1, wv[i]);
        for (int i = 0; i < 7; i++) begin apb(ofs[i], 0, 0); chk(rdat, ev[i]); end
        chk(32'(pin_out), 32'h6E);
        chk(32'(pin_oe), 32'h7F);
        chk(32'(sv), 32'hF);
        ser_val <= 4'h5;
        repeat (3) @(posedge clock);
        chk(32'(pin_out), 32'h7F);
        apb(12'h010, 0, 0);
        chk({rdat[31:1], rerr}, 32'h1);
        pstrb <= 4'hE;
        apb(SPE_OFS_PULLUP, 1, 0);
        pstrb <= 4'hF;
        apb(SPE_OFS_PULLUP, 0, 0); chk(rdat, 32'h7F);
        apb(SPE_OFS_PULLUP, 1, 32'h5A);
        ser_val <= 4'h0;
        apb(SPE_OFS_OPEN_DRAIN, 1, 32'h7F);
        apb(SPE_OFS_PIN_DATA, 1, 32'h55);
        repeat (3) @(posedge clock);
        chk({pin_pullup, pin_out, pin_oe}, {11'h0, 7'h5A, 7'h44, 7'h3B});
        apb(SPE_OFS_OPEN_DRAIN, 1, 0);
        apb(SPE_OFS_OUTPUT_ENABLE, 1, 0);
        ext_drv <= 7'h7F; ext_val <= 7'h22;
        repeat (5) @(posedge clock);
        chk({serial0_clock, sv}, 5'h13);
        apb(SPE_OFS_PIN_DATA, 0, 0); chk(rdat, 32'h22);
        apb(SPE_OFS_INPUT_ENABLE, 1, 0);
        repeat (5) @(posedge clock);
        chk(32'(sv), 32'h0);
        apb(SPE_OFS_PIN_DATA, 0, 0); chk(rdat, 32'h55);
        apb(SPE_OFS_FUNCTION_ONE, 1, 0);
        apb(SPE_OFS_FUNCTION_TWO, 1, 0);
        repeat (5) @(posedge clock);
        chk(32'(sv), 32'hF);
        apb(SPE_OFS_FUNCTION_ONE, 1, 32'h44);
        apb(SPE_OFS_INPUT_ENABLE, 1, 32'h7F);
        repeat (5) @(posedge clock);
        chk(32'(pin_out), 32'h11);
        chk({serial1_clock, serial0_clock, sv}, 6'h0F);
        ser_val <= 4'h8;
        repeat (3) @(posedge clock);
        chk(32'(pin_out), 32'h51);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(ofs[i], 0, 0);
            chk(rdat, 0);
        end
        chk({pin_pullup, pin_out, pin_oe}, 21'h0);
        chk(32'(sv), 32'hF);
        end_sim;
    end
endmodule : spe_port_tb
`default_nettype wire
